// ---- design/flow_cmd_pkg.sv ----
// Purpose: Shared constants for the special command decoder
// Assumes: Register numbers are the 1-indexed window numbers seen by the host
// Notes:   Timing derived from the 200 MHz system clock

package flow_cmd_pkg;

  // ----------------------------------------
  // Command window
  // ----------------------------------------
  localparam logic [15:0] CMD_ID_REG     = 16'h03e8;
  localparam logic [15:0] CMD_ARG_REG    = 16'h03e9;

  // ----------------------------------------
  // Command identifiers
  // ----------------------------------------
  localparam logic [15:0] CMD_TARE       = 16'h0004;
  localparam logic [15:0] CMD_TOT_RESET  = 16'h0005;
  localparam logic [15:0] CMD_CTRL_VAR   = 16'h000b;
  localparam logic [15:0] CMD_SP_SAVE    = 16'h000c;
  localparam logic [15:0] CMD_TOT_PAUSE  = 16'h000f;
  localparam logic [15:0] CMD_VALVE      = 16'h0010;
  localparam logic [15:0] CMD_GAIN_SAVE  = 16'h0011;
  localparam logic [15:0] CMD_SP_SOURCE  = 16'h0012;
  localparam logic [15:0] CMD_STATION    = 16'h7fff;
  localparam logic [15:0] CMD_BITRATE    = 16'h8000;

  // ----------------------------------------
  // Result codes
  // ----------------------------------------
  localparam logic [15:0] RES_OK         = 16'h0000;
  localparam logic [15:0] RES_BAD_CMD    = 16'h8001;
  localparam logic [15:0] RES_BAD_SET    = 16'h8002;
  localparam logic [15:0] RES_UNSUP      = 16'h8003;

  // ----------------------------------------
  // Argument limits and field codes
  // ----------------------------------------
  localparam logic [15:0] STATION_MIN    = 16'h0001;
  localparam logic [15:0] STATION_MAX    = 16'h00f7;
  localparam logic [15:0] BITRATE_MAX    = 16'h0005;
  localparam logic [1:0]  VALVE_NONE     = 2'h0;
  localparam logic [1:0]  VALVE_CLOSE    = 2'h1;
  localparam logic [1:0]  VALVE_OPEN     = 2'h2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] ID_RESET       = 16'h0000;
  localparam logic [15:0] RESULT_RESET   = 16'h0000;
  localparam logic [7:0]  STATION_RESET  = 8'h01;
  localparam logic [2:0]  BITRATE_RESET  = 3'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint      CLK_HZ         = 200_000_000;
  localparam longint      TARE_TIME_S    = 10;
  localparam longint      TARE_CYCLES    = TARE_TIME_S * CLK_HZ;

endpackage

// ---- design/tare_timer.sv ----
// Purpose: Times a zero-flow tare from start to completion
// Assumes: start and abort are one-cycle pulses, never together
// Notes:   Restart while busy reloads the full period

`timescale 1ns/1ps

module tare_timer #(
  parameter int unsigned CYCLES = 32'd2000000000
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);

  logic [31:0] count_r;
  logic        busy_r;
  logic        done_r;
  wire         lastTick = busy_r && (count_r == 32'h00000001);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 32'h00000000;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      done_r <= lastTick && !abort && !start;
      if (start) begin
        count_r <= CYCLES;
        busy_r  <= 1'b1;
      end else if (abort || lastTick) begin
        count_r <= 32'h00000000;
        busy_r  <= 1'b0;
      end else if (busy_r) begin
        count_r <= count_r - 32'h00000001;
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;

endmodule

// ---- design/flow_ctrl_special_command_decoder.sv ----
// Purpose: Decodes and runs host special commands from the two-register window
// Assumes: One register access per cycle; frameEnd pulses after a multi-register write
// Notes:   Actions and result settle one clock after frameEnd
//
// Behaviour
// - Id 4 arg 1 starts tare, arg 0 aborts; tare runs about ten seconds.
// - Id 5 arg 0 clears totalizer; id 15 pauses on 0, resumes on 1.
// - Id 11 selects loop variable: 0 mass flow, 1 volumetric flow.
// - Volumetric control is inoperative while density is out of range.
// - Id 12 arg 0 saves setpoint; saved setpoint restored at every power-up.
// - Id 16 valve override: 0 cancel, 1 force closed, 2 force open.
// - Id 17 arg 1 saves gains to non-volatile storage.
// - Id 18 setpoint source: 0 digital, 1 analog input.
// - Id 32767 takes station address 1..247, active after power cycle.
// - Id 32768 sets bitrate code 0..5, active after power cycle.
// - Result 0 success, 32769 bad id, 32770 bad setting, 32771 unsupported.
// - A write to the identifier register within a write frame triggers execution.
// - Identifier written without argument executes with argument zero.
// - Reading returns last identifier and result code of that command.

`timescale 1ns/1ps

module flow_ctrl_special_command_decoder #(
  parameter int unsigned TARE_CYCLES      = 32'(flow_cmd_pkg::TARE_CYCLES),
  parameter bit          ANALOG_SP_FITTED = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        frameEnd,
  output logic      [15:0] regRdData,
  output logic             regRdValid,
  output logic             regRdErr,
  input  wire logic        densityOutOfRange,
  input  wire logic [31:0] presentSetpoint,
  input  wire logic [31:0] storedSetpoint,
  output logic             setpointRestore,
  output logic      [31:0] restoredSetpoint,
  output logic             setpointSave,
  output logic      [31:0] setpointSaveData,
  output logic             gainSave,
  output logic             tareActive,
  output logic             tareDone,
  output logic             totalizerClear,
  output logic             totalizerPaused,
  output logic             controlVolumetric,
  output logic             volumetricInoperative,
  output logic      [1:0]  valveOverride,
  output logic             setpointAnalog,
  output logic      [7:0]  pendingStation,
  output logic      [2:0]  pendingBitrate,
  output logic             configSave
);

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  function automatic logic [15:0] cmdResult(input logic [15:0] id, input logic [15:0] arg,
                                            input logic analogOk);
    logic bin;
    bin = (arg <= 16'h0001);
    unique case (id)
      flow_cmd_pkg::CMD_TARE, flow_cmd_pkg::CMD_CTRL_VAR, flow_cmd_pkg::CMD_TOT_PAUSE:
        cmdResult = bin ? flow_cmd_pkg::RES_OK : flow_cmd_pkg::RES_BAD_SET;
      flow_cmd_pkg::CMD_TOT_RESET, flow_cmd_pkg::CMD_SP_SAVE:
        cmdResult = (arg == 16'h0000) ? flow_cmd_pkg::RES_OK : flow_cmd_pkg::RES_BAD_SET;
      flow_cmd_pkg::CMD_GAIN_SAVE:
        cmdResult = (arg == 16'h0001) ? flow_cmd_pkg::RES_OK : flow_cmd_pkg::RES_BAD_SET;
      flow_cmd_pkg::CMD_VALVE:
        cmdResult = (arg <= 16'h0002) ? flow_cmd_pkg::RES_OK : flow_cmd_pkg::RES_BAD_SET;
      flow_cmd_pkg::CMD_SP_SOURCE:
        cmdResult = !bin ? flow_cmd_pkg::RES_BAD_SET :
                    (arg == 16'h0001 && !analogOk) ? flow_cmd_pkg::RES_UNSUP : flow_cmd_pkg::RES_OK;
      flow_cmd_pkg::CMD_STATION:
        cmdResult = (arg >= flow_cmd_pkg::STATION_MIN && arg <= flow_cmd_pkg::STATION_MAX) ?
                    flow_cmd_pkg::RES_OK : flow_cmd_pkg::RES_BAD_SET;
      flow_cmd_pkg::CMD_BITRATE:
        cmdResult = (arg <= flow_cmd_pkg::BITRATE_MAX) ? flow_cmd_pkg::RES_OK : flow_cmd_pkg::RES_BAD_SET;
      default:
        cmdResult = flow_cmd_pkg::RES_BAD_CMD;
    endcase
  endfunction

  // ----------------------------------------
  // Window registers
  // ----------------------------------------
  logic [15:0] id_r;
  logic [15:0] arg_r;
  logic [15:0] result_r;
  logic        pending_r;

  wire idWr   = regWrEn && (regAddr == flow_cmd_pkg::CMD_ID_REG);
  wire argWr  = regWrEn && (regAddr == flow_cmd_pkg::CMD_ARG_REG);
  wire exec   = frameEnd && pending_r;
  wire [15:0] resNow = cmdResult(id_r, arg_r, ANALOG_SP_FITTED);
  wire ok     = exec && (resNow == flow_cmd_pkg::RES_OK);
  function automatic logic isCmd(input logic [15:0] id, input logic [15:0] which, input logic go);
    isCmd = go && (id == which);
  endfunction
  wire doTare    = isCmd(id_r, flow_cmd_pkg::CMD_TARE, ok);
  wire doTotClr  = isCmd(id_r, flow_cmd_pkg::CMD_TOT_RESET, ok);
  wire doCtrlVar = isCmd(id_r, flow_cmd_pkg::CMD_CTRL_VAR, ok);
  wire doSpSave  = isCmd(id_r, flow_cmd_pkg::CMD_SP_SAVE, ok);
  wire doPause   = isCmd(id_r, flow_cmd_pkg::CMD_TOT_PAUSE, ok);
  wire doValve   = isCmd(id_r, flow_cmd_pkg::CMD_VALVE, ok);
  wire doGain    = isCmd(id_r, flow_cmd_pkg::CMD_GAIN_SAVE, ok);
  wire doSource  = isCmd(id_r, flow_cmd_pkg::CMD_SP_SOURCE, ok);
  wire doStation = isCmd(id_r, flow_cmd_pkg::CMD_STATION, ok);
  wire doBitrate = isCmd(id_r, flow_cmd_pkg::CMD_BITRATE, ok);
  wire rdHit     = (regAddr == flow_cmd_pkg::CMD_ID_REG) || (regAddr == flow_cmd_pkg::CMD_ARG_REG);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      id_r      <= flow_cmd_pkg::ID_RESET;
      arg_r     <= 16'h0000;
      pending_r <= 1'b0;
      result_r  <= flow_cmd_pkg::RESULT_RESET;
    end else begin
      if (idWr) begin
        id_r      <= regWrData;
        arg_r     <= 16'h0000;
      end else if (argWr) begin
        arg_r     <= regWrData;
      end
      pending_r <= idWr || (pending_r && !frameEnd);
      if (exec) result_r <= resNow;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [15:0] rdData_r;
  logic        rdValid_r;
  logic        rdErr_r;
  wire [15:0] rdSel = (regAddr == flow_cmd_pkg::CMD_ID_REG) ? id_r :
                      (regAddr == flow_cmd_pkg::CMD_ARG_REG) ? result_r : 16'h0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_r  <= 16'h0000;
      rdValid_r <= 1'b0;
      rdErr_r   <= 1'b0;
    end else begin
      rdValid_r <= regRdEn;
      rdErr_r   <= regRdEn && !rdHit;
      if (regRdEn) rdData_r <= rdSel;
    end
  end

  // ----------------------------------------
  // Actions
  // ----------------------------------------
  logic        clr_r;
  logic        pause_r;
  logic        vol_r;
  logic [1:0]  valve_r;
  logic        analog_r;
  logic        spSave_r;
  logic [31:0] spData_r;
  logic        gain_r;
  logic [7:0]  station_r;
  logic [2:0]  bitrate_r;
  logic        cfgSave_r;
  logic        booted_r;
  logic        restore_r;
  logic [31:0] restoreData_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clr_r         <= 1'b0;
      pause_r       <= 1'b0;
      vol_r         <= 1'b0;
      valve_r       <= flow_cmd_pkg::VALVE_NONE;
      analog_r      <= 1'b0;
      spSave_r      <= 1'b0;
      spData_r      <= 32'h00000000;
      gain_r        <= 1'b0;
      station_r     <= flow_cmd_pkg::STATION_RESET;
      bitrate_r     <= flow_cmd_pkg::BITRATE_RESET;
      cfgSave_r     <= 1'b0;
      booted_r      <= 1'b0;
      restore_r     <= 1'b0;
      restoreData_r <= 32'h00000000;
    end else begin
      clr_r <= doTotClr;
      if (doPause) pause_r <= (arg_r == 16'h0000);
      if (doCtrlVar) vol_r <= arg_r[0];
      if (doValve) valve_r <= arg_r[1:0];
      if (doSource) analog_r <= arg_r[0];
      spSave_r <= doSpSave;
      if (doSpSave) spData_r <= presentSetpoint;
      booted_r  <= 1'b1;
      restore_r <= !booted_r;
      if (!booted_r) restoreData_r <= storedSetpoint;
      gain_r <= doGain;
      if (doStation) station_r <= arg_r[7:0];
      if (doBitrate) bitrate_r <= arg_r[2:0];
      cfgSave_r <= doStation || doBitrate;
    end
  end

  tare_timer #(.CYCLES (TARE_CYCLES)) u_tare (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (doTare && arg_r[0]),
    .abort   (doTare && !arg_r[0]),
    .busy    (tareActive),
    .done    (tareDone)
  );

  assign regRdData             = rdData_r;
  assign regRdValid            = rdValid_r;
  assign regRdErr              = rdErr_r;
  assign totalizerClear        = clr_r;
  assign totalizerPaused       = pause_r;
  assign controlVolumetric     = vol_r;
  assign volumetricInoperative = vol_r && densityOutOfRange;
  assign valveOverride         = valve_r;
  assign setpointAnalog        = analog_r;
  assign setpointSave          = spSave_r;
  assign setpointSaveData      = spData_r;
  assign gainSave              = gain_r;
  assign pendingStation        = station_r;
  assign pendingBitrate        = bitrate_r;
  assign configSave            = cfgSave_r;
  assign setpointRestore       = restore_r;
  assign restoredSetpoint      = restoreData_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_tare_start;
    @(posedge clk) disable iff (!reset_n) doTare && arg_r == 16'h0001 |=> tareActive [*8];
  endproperty
  a_tare_start: assert property (p_tare_start) else $error("tare did not start");
  property p_tot_clear;
    @(posedge clk) disable iff (!reset_n) totalizerClear |-> $past(exec) && $past(id_r) == 16'h0005;
  endproperty
  a_tot_clear: assert property (p_tot_clear) else $error("spurious totalizer clear");
  property p_ctrl_var;
    @(posedge clk) disable iff (!reset_n) exec && id_r == 16'h000b && arg_r == 16'h0001 |=> controlVolumetric;
  endproperty
  a_ctrl_var: assert property (p_ctrl_var) else $error("volumetric not selected");
  property p_vol_inop;
    @(posedge clk) disable iff (!reset_n) volumetricInoperative |-> controlVolumetric && densityOutOfRange;
  endproperty
  a_vol_inop: assert property (p_vol_inop) else $error("inoperative flag wrong");
  property p_restore;
    @(posedge clk) disable iff (!reset_n) setpointRestore |=> !setpointRestore [*4];
  endproperty
  a_restore: assert property (p_restore) else $error("restore not single pulse");
  property p_valve;
    @(posedge clk) disable iff (!reset_n) exec && id_r == 16'h0010 && arg_r == 16'h0002 |=> valveOverride == 2'h2;
  endproperty
  a_valve: assert property (p_valve) else $error("valve not forced open");
  property p_station;
    @(posedge clk) disable iff (!reset_n) pendingStation != 8'h00 && pendingStation <= 8'hf7;
  endproperty
  a_station: assert property (p_station) else $error("station address out of range");
  property p_bad_cmd;
    @(posedge clk) disable iff (!reset_n) exec && id_r == 16'h0007 |=>
      regRdValid == $past(regRdEn) && result_r == 16'h8001;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("unknown id not flagged");
  property p_default_arg;
    @(posedge clk) disable iff (!reset_n) idWr |=> arg_r == 16'h0000;
  endproperty
  a_default_arg: assert property (p_default_arg) else $error("argument not defaulted");
  property p_bad_set;
    @(posedge clk) disable iff (!reset_n) exec && id_r == 16'h0010 && arg_r > 16'h0002 |=>
      $stable(valveOverride) && result_r == 16'h8002;
  endproperty
  a_bad_set: assert property (p_bad_set) else $error("bad setting changed state");

endmodule

// ---- sim/modbus_host_model.sv ----
// Purpose: Host side of the command window, write frames and reads
// Assumes: One register word per cycle, frameEnd after the last word
// Notes:   Tasks are called by the testbench through the instance name

`timescale 1ns/1ps

module modbus_host_model (
  input  wire logic        clk,
  output logic             regWrEn,
  output logic             regRdEn,
  output logic      [15:0] regAddr,
  output logic      [15:0] regWrData,
  output logic             frameEnd,
  input  wire logic [15:0] regRdData,
  input  wire logic        regRdValid,
  input  wire logic        regRdErr
);
  // ----------------------------------------
  // Frames
  // ----------------------------------------
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 16'h0000;
    regWrData = 16'h0000;
    frameEnd  = 1'b0;
  end

  task automatic writeFrame(input logic [15:0] id, input logic [15:0] arg, input bit withId, input bit withArg);
    @(posedge clk);
    if (withId) begin
      regWrEn   <= 1'b1;
      regAddr   <= flow_cmd_pkg::CMD_ID_REG;
      regWrData <= id;
      @(posedge clk);
    end
    if (withArg) begin
      regWrEn   <= 1'b1;
      regAddr   <= flow_cmd_pkg::CMD_ARG_REG;
      regWrData <= arg;
      @(posedge clk);
    end
    // Released bus shows garbage, not the last word
    regWrEn   <= 1'b0;
    regAddr   <= ~regAddr;
    regWrData <= ~regWrData;
    frameEnd  <= 1'b1;
    @(posedge clk);
    frameEnd  <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic readReg(input logic [15:0] addr, output logic [15:0] data, output logic err, output bit got);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= addr;
    @(posedge clk);
    regRdEn <= 1'b0;
    regAddr <= ~addr;
    got = 1'b0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(negedge clk);
      if (regRdValid === 1'b1) begin
        got  = 1'b1;
        data = regRdData;
        err  = regRdErr;
      end
    end
  endtask
endmodule

// ---- sim/test_flow_ctrl_special_command_decoder.sv ----
// Purpose: Self-checking bench for the special command decoder
// Assumes: Host model drives the register window
// Notes:   Tare shortened to 20 cycles; pulses are counted at negedge

`timescale 1ns/1ps

module test_flow_ctrl_special_command_decoder;
  localparam int unsigned TARE_N = 20;
  logic        clk, reset_n, regWrEn, regRdEn, frameEnd, densityOutOfRange, regRdValid, regRdErr;
  logic [15:0] regAddr, regWrData, regRdData;
  logic        setpointRestore, setpointSave, gainSave, tareActive, tareDone, totalizerClear;
  logic        totalizerPaused, controlVolumetric, volumetricInoperative, setpointAnalog, configSave;
  logic [31:0] presentSetpoint, storedSetpoint, restoredSetpoint, setpointSaveData, restoreVal, snap;
  logic [1:0]  valveOverride;
  logic [7:0]  pendingStation;
  logic [2:0]  pendingBitrate;
  logic [15:0] altRdData;
  logic        altAnalog;
  wire  [31:0] stateWord = {16'h0000, totalizerPaused, controlVolumetric, valveOverride, setpointAnalog,
                            pendingStation, pendingBitrate};
  int          n_mismatch, cmp_count, nRestore, nClr, nSpSave, nGain, nCfg, nDone, c;
  logic [15:0] badId [11] = '{16'h0004, 16'h0005, 16'h000b, 16'h000c, 16'h000f, 16'h0010,
                              16'h0011, 16'h0012, 16'h7fff, 16'h7fff, 16'h8000};
  logic [15:0] badArg [11] = '{16'h0002, 16'h0001, 16'h0002, 16'h0001, 16'h0002, 16'h0003,
                               16'h0000, 16'h0002, 16'h0000, 16'h00f8, 16'h0006};

  flow_ctrl_special_command_decoder #(.TARE_CYCLES(TARE_N), .ANALOG_SP_FITTED(1'b1)) DUT (
    .clk, .reset_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .frameEnd, .regRdData, .regRdValid,
    .regRdErr, .densityOutOfRange, .presentSetpoint, .storedSetpoint, .setpointRestore,
    .restoredSetpoint, .setpointSave, .setpointSaveData, .gainSave, .tareActive, .tareDone,
    .totalizerClear, .totalizerPaused, .controlVolumetric, .volumetricInoperative, .valveOverride,
    .setpointAnalog, .pendingStation, .pendingBitrate, .configSave);

  modbus_host_model host (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .frameEnd, .regRdData,
                          .regRdValid, .regRdErr);

  // Copy without the analog input, the only way to reach the unsupported code
  flow_ctrl_special_command_decoder #(.TARE_CYCLES(TARE_N), .ANALOG_SP_FITTED(1'b0)) noAnalog (
    .clk, .reset_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .frameEnd, .regRdData(altRdData),
    .regRdValid(), .regRdErr(), .densityOutOfRange, .presentSetpoint, .storedSetpoint,
    .setpointRestore(), .restoredSetpoint(), .setpointSave(), .setpointSaveData(), .gainSave(),
    .tareActive(), .tareDone(), .totalizerClear(), .totalizerPaused(), .controlVolumetric(),
    .volumetricInoperative(), .valveOverride(), .setpointAnalog(altAnalog), .pendingStation(),
    .pendingBitrate(), .configSave());

  // ----------------------------------------
  // Clock, pulse counters, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (setpointRestore === 1'b1) begin
      nRestore++;
      restoreVal = restoredSetpoint;
    end
    nClr    += (totalizerClear === 1'b1);
    nSpSave += (setpointSave === 1'b1);
    nGain   += (gainSave === 1'b1);
    nCfg    += (configSave === 1'b1);
    nDone   += (tareDone === 1'b1);
  end

  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input logic expErr);
    logic [15:0] d;
    logic        e;
    bit          g;
    host.readReg(addr, d, e, g);
    chk({31'h0, g}, 32'h1);
    chk({16'h0, d}, {16'h0, exp});
    chk({31'h0, e}, {31'h0, expErr});
  endtask

  task automatic cmd(input logic [15:0] id, input logic [15:0] arg, input bit withArg, input logic [15:0] res);
    host.writeFrame(id, arg, 1'b1, withArg);
    rd(16'h03e9, res, 1'b0);
    rd(16'h03e8, id, 1'b0);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    densityOutOfRange = 1'b0;
    presentSetpoint = 32'h0badcafe;
    storedSetpoint = 32'h1234abcd;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(nRestore, 1);
    chk(restoreVal, 32'h1234abcd);
    chk({24'h0, pendingStation}, 32'h01);
    chk({29'h0, pendingBitrate}, 32'h2);
    rd(16'h03e8, 16'h0000, 1'b0);
    rd(16'h03ea, 16'h0000, 1'b1);
    // every valve code, then a bad one
    for (int a = 0; a < 3; a++) begin
      cmd(16'h0010, a[15:0], 1'b1, 16'h0000);
      chk({30'h0, valveOverride}, a);
    end
    cmd(16'h0010, 16'h0003, 1'b1, 16'h8002);
    host.writeFrame(16'h0000, 16'h0000, 1'b0, 1'b1);
    rd(16'h03e9, 16'h8002, 1'b0);
    chk({30'h0, valveOverride}, 32'h2);
    cmd(16'h0010, 16'h0000, 1'b0, 16'h0000);
    chk({30'h0, valveOverride}, 32'h0);
    // full tare, then start and abort
    c = nDone;
    cmd(16'h0004, 16'h0001, 1'b1, 16'h0000);
    chk({31'h0, tareActive}, 32'h1);
    repeat (TARE_N + 5) @(posedge clk);
    chk({31'h0, tareActive}, 32'h0);
    chk(nDone, c + 1);
    cmd(16'h0004, 16'h0001, 1'b1, 16'h0000);
    cmd(16'h0004, 16'h0000, 1'b1, 16'h0000);
    chk({31'h0, tareActive}, 32'h0);
    repeat (TARE_N + 5) @(posedge clk);
    chk(nDone, c + 1);
    c = nClr;
    cmd(16'h0005, 16'h0000, 1'b1, 16'h0000);
    chk(nClr, c + 1);
    cmd(16'h000f, 16'h0000, 1'b1, 16'h0000);
    chk({31'h0, totalizerPaused}, 32'h1);
    cmd(16'h000f, 16'h0001, 1'b1, 16'h0000);
    chk({31'h0, totalizerPaused}, 32'h0);
    cmd(16'h000b, 16'h0001, 1'b1, 16'h0000);
    chk({31'h0, controlVolumetric}, 32'h1);
    chk({31'h0, volumetricInoperative}, 32'h0);
    @(posedge clk);
    densityOutOfRange <= 1'b1;
    @(negedge clk);
    chk({31'h0, volumetricInoperative}, 32'h1);
    cmd(16'h000b, 16'h0000, 1'b1, 16'h0000);
    chk({30'h0, controlVolumetric, volumetricInoperative}, 32'h0);
    c = nSpSave;
    cmd(16'h000c, 16'h0000, 1'b1, 16'h0000);
    chk(nSpSave, c + 1);
    chk(setpointSaveData, 32'h0badcafe);
    c = nGain;
    cmd(16'h0011, 16'h0001, 1'b1, 16'h0000);
    chk(nGain, c + 1);
    cmd(16'h0012, 16'h0001, 1'b1, 16'h0000);
    chk({31'h0, setpointAnalog}, 32'h1);
    rd(16'h03e9, 16'h0000, 1'b0);
    chk({16'h0, altRdData}, 32'h8003);
    chk({31'h0, altAnalog}, 32'h0);
    cmd(16'h0012, 16'h0000, 1'b1, 16'h0000);
    chk({31'h0, setpointAnalog}, 32'h0);
    c = nCfg;
    cmd(16'h7fff, 16'h00f7, 1'b1, 16'h0000);
    chk({24'h0, pendingStation}, 32'hf7);
    cmd(16'h7fff, 16'h0001, 1'b1, 16'h0000);
    chk({24'h0, pendingStation}, 32'h01);
    for (int a = 0; a < 6; a++) begin
      cmd(16'h8000, a[15:0], 1'b1, 16'h0000);
      chk({29'h0, pendingBitrate}, a);
    end
    chk(nCfg, c + 8);
    cmd(16'h0007, 16'h0000, 1'b1, 16'h8001);
    cmd(16'h8001, 16'h0000, 1'b1, 16'h8001);
    // bad setting leaves all state alone
    snap = stateWord;
    c = nClr + nSpSave + nGain + nCfg + nDone;
    for (int i = 0; i < 11; i++) cmd(badId[i], badArg[i], 1'b1, 16'h8002);
    chk(stateWord, snap);
    chk(nClr + nSpSave + nGain + nCfg + nDone, c);
    chk({31'h0, tareActive}, 32'h0);
    // a second power-up restores the stored setpoint again
    storedSetpoint <= 32'h5a5a0f0f;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(nRestore, 2);
    chk(restoreVal, 32'h5a5a0f0f);
    summarize();
  end
endmodule
